// [rtl/drvil_defs.svh]
/*
  Constants of the drive run interlock and output supervisor.
  Assumes a 20 MHz system clock.
*/
`ifndef DRVIL_DEFS_SVH
`define DRVIL_DEFS_SVH
`define DRVIL_CLK_HZ 20000000
`define DRVIL_RESTART_LOW_MS 50
`define DRVIL_RESTART_LOW_CYC ((`DRVIL_CLK_HZ / 1000) * `DRVIL_RESTART_LOW_MS)
`define DRVIL_COAST_STOP_INPUT_MAX_MS 100
`define DRVIL_COAST_STOP_INPUT_MAX_CYC ((`DRVIL_CLK_HZ / 1000) * `DRVIL_COAST_STOP_INPUT_MAX_MS)
`define DRVIL_ENC_MAX_HZ 100000
`define DRVIL_ENC_MIN_CYC (`DRVIL_CLK_HZ / `DRVIL_ENC_MAX_HZ)
`define DRVIL_NUM_DIO 4
`define DRVIL_NUM_DOP 3
`define DRVIL_NUM_OUT 7
`define DRVIL_NUM_UIP 8
`define DRVIL_ADC_W 12
`define DRVIL_POS_W 16
`define DRVIL_TMR_W 21
`define DRVIL_ENC_SINGLE 2'h0
`define DRVIL_ENC_SIGN 2'h1
`define DRVIL_ENC_QUAD 2'h2
`endif

// [rtl/drvil_pkg.sv]
/*
  Types of the drive run interlock block.
  Assumes drvil_defs.svh is compiled alongside.
*/
package drvil_pkg;
  typedef enum logic [1:0] {
    DRVIL_IDLE = 2'b00,
    DRVIL_RUN = 2'b01,
    DRVIL_STOPPING = 2'b10,
    DRVIL_LOCKED = 2'b11
  } drvil_state_e;
endpackage : drvil_pkg

// [rtl/drvil_encoder.sv]
/*
  Encoder front end: single pulse, pulse with sign, or quadrature
  counting, plus marker capture.
  Assumes inputs are already synchronised to clk_sys.
*/
`timescale 1ns/1ps
`include "drvil_defs.svh"
module drvil_encoder (
  input wire logic clk_sys, // System clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic [1:0] encMode, // Encoder format select.
  input wire logic encA, // Synchronised A train.
  input wire logic encB, // Synchronised B train or sign.
  input wire logic marker, // Synchronised marker pulse.
  output logic [`DRVIL_POS_W-1:0] encCount, // Position count.
  output logic [`DRVIL_POS_W-1:0] markerPos, // Count at last marker.
  output logic markerSeen // One-cycle pulse at marker edge.
);
  logic [`DRVIL_POS_W-1:0] count_q, count_d, mpos_q, mpos_d;
  logic aPrev_q, bPrev_q, mPrev_q, mSeen_q, mSeen_d;
  logic [1:0] step;

  // Returns +1, -1 or 0 as a two bit code: 01 up, 11 down.
  function automatic logic [1:0] quadStep(input logic pa, input logic pb,
                                          input logic na, input logic nb);
    if ((pa ^ na) && !(pb ^ nb)) begin
      quadStep = (na ^ nb) ? 2'b11 : 2'b01;
    end else if ((pb ^ nb) && !(pa ^ na)) begin
      quadStep = (na ^ nb) ? 2'b01 : 2'b11;
    end else begin
      quadStep = 2'b00;
    end
  endfunction : quadStep

  // Counting one step per clock keeps up far beyond the top pulse rate.
  always_comb begin
    step = 2'b00;
    case (encMode)
      `DRVIL_ENC_SINGLE: step = (encA && !aPrev_q) ? 2'b01 : 2'b00;
      `DRVIL_ENC_SIGN:
        step = (encA && !aPrev_q) ? (encB ? 2'b11 : 2'b01) : 2'b00;
      `DRVIL_ENC_QUAD: step = quadStep(aPrev_q, bPrev_q, encA, encB);
      default: step = 2'b00;
    endcase
    count_d = count_q;
    if (step == 2'b01) begin
      count_d = count_q + 16'h0001;
    end else if (step == 2'b11) begin
      count_d = count_q - 16'h0001;
    end
    mSeen_d = marker && !mPrev_q;
    mpos_d = mSeen_d ? count_q : mpos_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      count_q <= 16'h0000;
      mpos_q <= 16'h0000;
      aPrev_q <= 1'b0;
      bPrev_q <= 1'b0;
      mPrev_q <= 1'b0;
      mSeen_q <= 1'b0;
    end else begin
      count_q <= count_d;
      mpos_q <= mpos_d;
      aPrev_q <= encA;
      bPrev_q <= encB;
      mPrev_q <= marker;
      mSeen_q <= mSeen_d;
    end
  end

  assign encCount = count_q;
  assign markerPos = mpos_q;
  assign markerSeen = mSeen_q;
endmodule : drvil_encoder

// [rtl/drvil_top.sv]
/*
  Run interlock, digital output short supervisor and input front end
  of a DC motor drive controller.
  Assumes one 20 MHz clock; terminal levels arrive asynchronously and
  are synchronised here; analogue samples and the short sense come from
  logic on the same clock.
*/
`timescale 1ns/1ps
`include "drvil_defs.svh"
// Operation
// - A start is honoured only when no alarm is active.
// - After an alarm drop-out, start must be low 50 ms then high again; if coast stop is low in that cycle the state stays locked, with no restart.
// - Withdrawing start keeps the contactor closed until zero speed.
// - Coast stop low opens the contactor at once, well within 100 ms.
// - The contactor closes only on start or jog with coast stop high.
// - The latch contacts switch together with the contactor contacts.
// - A short on any digital output disables all outputs and flags it.
// - A setting enables a trip on output short; off, running goes on.
// - A selected output can show the short by going low.
// - When the short clears, outputs return to their former states.
// - The encoder takes single pulse, pulse with sign or quadrature.
// - The encoder counts pulse trains up to 100 kHz correctly.
// - A marker input gives a once-per-revolution reference.
// - Each of the 4 bidirectional terminals is an input or output.
// - Each of the 8 analogue inputs can act as a logic input.
module drvil_top (
  input wire logic clk_sys, // 20 MHz system clock.
  input wire logic resetn, // Synchronous reset, active low.
  input wire logic startInput, // Start terminal level.
  input wire logic jogInput, // Jog terminal level.
  input wire logic coast_stop_input, // Coast stop, low stops.
  input wire logic alarmActive, // Any drive alarm active.
  input wire logic zeroSpeed, // Motor at zero speed.
  output logic contactor_contact_a, // Main contactor contact, side a.
  output logic contactor_contact_b, // Main contactor contact, side b.
  output logic latch_contact_a, // Latch contact, side a.
  output logic latch_contact_b, // Latch contact, side b.
  output logic runActive, // Drive is in the run state.
  input wire logic [`DRVIL_NUM_OUT-1:0] outShortSense, // Per-output short.
  input wire logic [`DRVIL_NUM_DOP-1:0] logicOutReq, // Wanted DOP levels.
  output logic [`DRVIL_NUM_DOP-1:0] logicOutPin, // DOP drive levels.
  output logic [`DRVIL_NUM_DOP-1:0] logicOutEn, // DOP drive enable.
  input wire logic shortTripEnable, // Trip the drive on output short.
  input wire logic shortIndicateEnable, // Show short on one output.
  input wire logic [2:0] shortIndicateSel, // Output that shows short.
  output logic shortCircuitFlag, // Output short present.
  output logic shortTrip, // Short taken as a drive alarm.
  input wire logic [`DRVIL_NUM_DIO-1:0] dioIsOutput, // 1: terminal output.
  input wire logic [`DRVIL_NUM_DIO-1:0] dioOutReq, // Wanted DIO levels.
  input wire logic [`DRVIL_NUM_DIO-1:0] bidirTerminalIn, // DIO pin levels.
  output logic [`DRVIL_NUM_DIO-1:0] bidirTerminalOut, // DIO drive level.
  output logic [`DRVIL_NUM_DIO-1:0] bidirTerminalOe, // DIO drive enable.
  output logic [`DRVIL_NUM_DIO-1:0] dioInLevel, // DIO levels read.
  input wire logic [`DRVIL_NUM_UIP*`DRVIL_ADC_W-1:0] uipSample, // Samples.
  input wire logic [`DRVIL_ADC_W-1:0] uipThreshold, // Logic threshold.
  output logic [`DRVIL_NUM_UIP-1:0] uipLogic, // Analogue inputs as logic.
  input wire logic [1:0] encMode, // Encoder format.
  input wire logic encoder_a_input, // Encoder A train.
  input wire logic encoder_b_or_direction_input, // Encoder B or sign.
  input wire logic marker_pulse_input, // Marker pulse.
  output logic [`DRVIL_POS_W-1:0] encCount, // Encoder count.
  output logic [`DRVIL_POS_W-1:0] markerPos, // Count at marker.
  output logic markerSeen // Marker edge pulse.
);
  localparam int unsigned SyncW = 7 + `DRVIL_NUM_DIO;
  localparam logic [`DRVIL_TMR_W-1:0] LowCyc =
    `DRVIL_TMR_W'(`DRVIL_RESTART_LOW_CYC);

  // Terminal synchronisers: first stage feeds only the second.
  logic [SyncW-1:0] syncRaw;
  logic [SyncW-1:0] sync1_q;
  logic [SyncW-1:0] sync2_q;
  assign syncRaw = {startInput, jogInput, coast_stop_input, zeroSpeed,
                    encoder_a_input, encoder_b_or_direction_input,
                    marker_pulse_input, bidirTerminalIn};
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= syncRaw;
      sync2_q <= sync1_q;
    end
  end

  logic startS;
  logic jogS;
  logic cstopS;
  logic zeroS;
  logic encAS;
  logic encBS;
  logic markS;
  logic [`DRVIL_NUM_DIO-1:0] dioS;
  assign {startS, jogS, cstopS, zeroS, encAS, encBS, markS, dioS} = sync2_q;


  // Output short supervision.
  logic shortNow;
  logic shortFlag_q;
  logic shortFlag_d;
  logic trip_q;
  logic trip_d;
  assign shortNow = |outShortSense;
  always_comb begin
    shortFlag_d = shortNow;
    // The trip holds until the short has cleared and start is removed.
    trip_d = trip_q;
    if (shortNow && shortTripEnable) begin
      trip_d = 1'b1;
    end else if (!shortNow && !startS) begin
      trip_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      shortFlag_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      shortFlag_q <= shortFlag_d;
      trip_q <= trip_d;
    end
  end

  // Run interlock.
  drvil_pkg::drvil_state_e state_q, state_d;
  logic [`DRVIL_TMR_W-1:0] lowCnt_q, lowCnt_d;
  logic lowDone_q;
  logic lowDone_d;
  logic closed_q;
  logic closed_d;
  logic alarmAll;
  logic cmd;
  // A short trip joins the alarms, so it shares the restart rule.
  assign alarmAll = alarmActive || trip_q;
  assign cmd = startS || jogS;

  // The contacts are closed in the two states that power the motor.
  function automatic logic isPowered(input drvil_pkg::drvil_state_e s);
    isPowered = (s == drvil_pkg::DRVIL_RUN) ||
                (s == drvil_pkg::DRVIL_STOPPING);
  endfunction : isPowered

  always_comb begin
    state_d = state_q;
    closed_d = closed_q;
    lowCnt_d = lowCnt_q;
    lowDone_d = lowDone_q;
    case (state_q)
      drvil_pkg::DRVIL_IDLE: begin
        if (cmd && cstopS && !alarmAll) begin
          state_d = drvil_pkg::DRVIL_RUN;
        end
      end
      drvil_pkg::DRVIL_RUN: begin
        if (alarmAll) begin
          state_d = drvil_pkg::DRVIL_LOCKED;
        end else if (!cmd) begin
          state_d = drvil_pkg::DRVIL_STOPPING;
        end
      end
      drvil_pkg::DRVIL_STOPPING: begin
        if (alarmAll) begin
          state_d = drvil_pkg::DRVIL_LOCKED;
        end else if (cmd) begin
          state_d = drvil_pkg::DRVIL_RUN;
        end else if (zeroS) begin
          state_d = drvil_pkg::DRVIL_IDLE;
        end
      end
      drvil_pkg::DRVIL_LOCKED: begin
        // Start must be seen low for the full time, then high again.
        if (startS) begin
          if (lowDone_q && !alarmAll && cstopS) begin
            state_d = drvil_pkg::DRVIL_RUN;
          end
          lowCnt_d = '0;
        end else if (lowCnt_q < LowCyc) begin
          lowCnt_d = lowCnt_q + `DRVIL_TMR_W'(1);
        end else begin
          lowDone_d = 1'b1;
        end
      end
      default: state_d = drvil_pkg::DRVIL_IDLE;
    endcase
    if (state_d != drvil_pkg::DRVIL_LOCKED) begin
      lowCnt_d = '0;
      lowDone_d = 1'b0;
    end
    if (!cstopS) begin
      // Coast stop opens the contact next cycle, far inside 100 ms.
      state_d = (state_q == drvil_pkg::DRVIL_LOCKED) ?
                drvil_pkg::DRVIL_LOCKED : drvil_pkg::DRVIL_IDLE;
    end
    closed_d = cstopS && isPowered(state_d);
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= drvil_pkg::DRVIL_IDLE;
      lowCnt_q <= '0;
      lowDone_q <= 1'b0;
      closed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lowCnt_q <= lowCnt_d;
      lowDone_q <= lowDone_d;
      closed_q <= closed_d;
    end
  end

  // Both contact pairs come from the same flip-flop, so they never skew.
  assign contactor_contact_a = closed_q;
  assign contactor_contact_b = closed_q;
  assign latch_contact_a = closed_q;
  assign latch_contact_b = closed_q;
  assign runActive = (state_q == drvil_pkg::DRVIL_RUN);
  assign shortCircuitFlag = shortFlag_q;
  assign shortTrip = trip_q;

  // Digital outputs. Levels are reloaded from the live requests every cycle, so
  // each output simply resumes its requested level once the short clears.
  logic [`DRVIL_NUM_OUT-1:0] outLvl_q;
  logic [`DRVIL_NUM_OUT-1:0] outLvl_d;
  logic [`DRVIL_NUM_OUT-1:0] outEn_q;
  logic [`DRVIL_NUM_OUT-1:0] outEn_d;
  logic [`DRVIL_NUM_OUT-1:0] isOut;
  assign isOut = {dioIsOutput, {`DRVIL_NUM_DOP{1'b1}}};

  always_comb begin
    outLvl_d = {dioOutReq, logicOutReq};
    outEn_d = isOut;
    if (shortNow) begin
      outEn_d = '0;
    end
    if (shortIndicateEnable && shortNow &&
        (shortIndicateSel < 3'(`DRVIL_NUM_OUT))) begin
      // Low on an undriven pin relies on the external pull-down.
      outLvl_d[shortIndicateSel] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      outLvl_q <= '0;
      outEn_q <= '0;
    end else begin
      outLvl_q <= outLvl_d;
      outEn_q <= outEn_d;
    end
  end

  // Dual-use inputs. A terminal set as an output reads as low, so the
  // level it drives itself never leaks into the input image.
  logic [`DRVIL_NUM_UIP-1:0] uip_q;
  logic [`DRVIL_NUM_UIP-1:0] uip_d;
  logic [`DRVIL_NUM_DIO-1:0] dioIn_q;
  logic [`DRVIL_NUM_DIO-1:0] dioIn_d;

  always_comb begin
    dioIn_d = dioS & ~dioIsOutput;
    for (int i = 0; i < `DRVIL_NUM_UIP; i++) begin
      uip_d[i] = uipSample[i*`DRVIL_ADC_W +: `DRVIL_ADC_W] >=
                 uipThreshold;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      uip_q <= '0;
      dioIn_q <= '0;
    end else begin
      uip_q <= uip_d;
      dioIn_q <= dioIn_d;
    end
  end

  assign logicOutPin = outLvl_q[`DRVIL_NUM_DOP-1:0];
  assign logicOutEn = outEn_q[`DRVIL_NUM_DOP-1:0];
  assign bidirTerminalOut = outLvl_q[`DRVIL_NUM_OUT-1:`DRVIL_NUM_DOP];
  assign bidirTerminalOe = outEn_q[`DRVIL_NUM_OUT-1:`DRVIL_NUM_DOP];
  assign dioInLevel = dioIn_q;
  assign uipLogic = uip_q;

  // The encoder sees only synchronised levels; its count wraps at the
  // width of the position word, which the user must allow for.
  drvil_encoder u_enc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .encMode(encMode),
    .encA(encAS),
    .encB(encBS),
    .marker(markS),
    .encCount(encCount),
    .markerPos(markerPos),
    .markerSeen(markerSeen)
  );
endmodule : drvil_top

// [tb/drvil_top_properties.sv]
/* Port checker of drvil_top, bound to every instance of it.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module drvil_checker (
  input wire logic clk_sys, // Clock.
  input wire logic resetn, // Reset.
  input wire logic coast_stop_input, // Coast stop.
  input wire logic alarmActive, // Alarm.
  input wire logic zeroSpeed, // Zero speed.
  input wire logic contactor_contact_a, // Contact a.
  input wire logic contactor_contact_b, // Contact b.
  input wire logic latch_contact_a, // Latch a.
  input wire logic latch_contact_b, // Latch b.
  input wire logic [6:0] outShortSense, // Short sense.
  input wire logic [2:0] logicOutReq, // Wanted levels.
  input wire logic [2:0] logicOutPin, // Levels.
  input wire logic [2:0] logicOutEn, // Enables.
  input wire logic shortTripEnable, // Trip setting.
  input wire logic shortIndicateEnable, // Indicate setting.
  input wire logic [2:0] shortIndicateSel, // Indicate output.
  input wire logic shortCircuitFlag, // Short flag.
  input wire logic shortTrip, // Short trip.
  input wire logic [3:0] dioIsOutput, // Direction.
  input wire logic [3:0] bidirTerminalOe // Enables.
);
  logic [2:0] hold_q;
  logic [2:0] hold_d;
  // Terminal levels take three edges to act, so the hold check trusts
  // only conditions that have stood that long.
  always_comb begin
    hold_d = {hold_q[1:0], !zeroSpeed && coast_stop_input && !alarmActive};
  end
  always_ff @(posedge clk_sys) begin
    hold_q <= hold_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_latch_follows: assert property (
    latch_contact_a == contactor_contact_a && latch_contact_b ==
    contactor_contact_a && contactor_contact_b == contactor_contact_a)
    else $error("latch and contactor contacts differ");
  a_close_coast: assert property (
    $rose(contactor_contact_a) |-> $past(coast_stop_input, 3))
    else $error("contactor closed without coast stop high");
  a_coast_opens: assert property (
    !coast_stop_input |-> ##[1:4] !contactor_contact_a)
    else $error("coast stop did not open the contactor");
  a_start_clear: assert property (
    $rose(contactor_contact_a) |-> !$past(alarmActive) && !$past(shortTrip))
    else $error("contactor closed during an alarm");
  a_alarm_drops: assert property (
    alarmActive |=> !contactor_contact_a)
    else $error("alarm did not drop the contactor");
  a_hold_zero: assert property (
    contactor_contact_a && (&hold_q) && hold_d[0] && !shortTrip &&
    !shortTripEnable |=> contactor_contact_a)
    else $error("contactor opened before zero speed");
  a_short_off: assert property (
    |outShortSense |=> shortCircuitFlag && logicOutEn == 3'h0 &&
    bidirTerminalOe == 4'h0)
    else $error("short did not disable outputs");
  a_short_shown: assert property (
    shortCircuitFlag && shortIndicateEnable && shortIndicateSel < 3'h3
    |-> logicOutPin[shortIndicateSel] == 1'h0)
    else $error("indicating output not low");
  a_outputs_restore: assert property (
    $fell(shortCircuitFlag) |-> logicOutPin == $past(logicOutReq) &&
    logicOutEn == 3'h7 && bidirTerminalOe == $past(dioIsOutput))
    else $error("outputs not restored after short");
  a_trip_cause: assert property (
    $rose(shortTrip) |-> $past(shortTripEnable) && $past(|outShortSense))
    else $error("trip without enabled short");
  a_trip_opens: assert property (
    shortTrip |=> !contactor_contact_a)
    else $error("short trip left contactor closed");
  c_run: cover property ($rose(contactor_contact_a));
  c_restore: cover property ($fell(shortCircuitFlag));
  c_trip: cover property ($rose(shortTrip));
endmodule : drvil_checker
bind drvil_top drvil_checker u_drvil_checker (.clk_sys, .resetn,
  .coast_stop_input, .alarmActive, .zeroSpeed, .contactor_contact_a,
  .contactor_contact_b, .latch_contact_a, .latch_contact_b, .outShortSense,
  .logicOutReq, .logicOutPin, .logicOutEn, .shortTripEnable,
  .shortIndicateEnable, .shortIndicateSel, .shortCircuitFlag, .shortTrip,
  .dioIsOutput, .bidirTerminalOe);

// [tb/drvil_plant.sv]
/* Far-side model: motor spin-down and an encoder with marker.
   Assumes the bench calls spin and mark from its own process. */
`timescale 1ns/1ps
module drvil_plant (
  input wire logic clk_sys, // System clock.
  input wire logic driveRun, // Drive powering the motor.
  output logic zeroSpeed, // Motor standing.
  output logic encA, // A train.
  output logic encB, // B train or sign.
  output logic marker // Marker pulse.
);
  logic [5:0] speed_q = 6'h00;
  // The motor coasts 40 cycles, so a stop has a tail the drive must wait.
  always @(posedge clk_sys) begin
    speed_q <= driveRun ? 6'h28 : speed_q - {5'h00, |speed_q};
  end
  assign zeroSpeed = speed_q == 6'h00;
  initial begin
    encA = 1'h0;
    encB = 1'h0;
    marker = 1'h0;
  end
  task automatic qtr();
    repeat (50) @(posedge clk_sys);
    #2;
  endtask : qtr
  // Quarter periods of 50 cycles give the top rate of 100 kHz.
  task automatic spin(input int n, input logic sgn, input logic quad);
    encB = quad ? 1'h0 : sgn;
    for (int i = 0; i < n; i++) begin
      qtr();
      encA = 1'h1;
      qtr();
      if (quad) encB = 1'h1;
      qtr();
      encA = 1'h0;
      qtr();
      if (quad) encB = 1'h0;
    end
    qtr();
    encB = 1'h0;
  endtask : spin
  task automatic mark();
    qtr();
    marker = 1'h1;
    qtr();
    marker = 1'h0;
  endtask : mark
endmodule : drvil_plant

// [tb/tb_top.sv]
/* Self-checking bench of drvil_top with the plant model.
   Assumes the design, its header and the plant are compiled first. */
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, resetn = 1'h0, startInput = 1'h0, jogInput = 1'h0;
  logic coast_stop_input = 1'h1, alarmActive = 1'h0, zeroSpeed, runActive;
  logic contactor_contact_a, contactor_contact_b, markerSeen;
  logic latch_contact_a, latch_contact_b, shortCircuitFlag, shortTrip;
  logic [6:0] outShortSense = 7'h00;
  logic [2:0] logicOutReq = 3'h5, logicOutPin, logicOutEn;
  logic shortTripEnable = 1'h0, shortIndicateEnable = 1'h1;
  logic [2:0] shortIndicateSel = 3'h2;
  logic [3:0] dioIsOutput = 4'h3, dioOutReq = 4'h1, dioExt = 4'hf;
  logic [3:0] bidirTerminalIn, bidirTerminalOut, bidirTerminalOe, dioInLevel;
  logic [95:0] uipSample = 96'h0;
  logic [11:0] uipThreshold = 12'h800;
  logic [7:0] uipLogic;
  logic [1:0] encMode = 2'h0;
  logic encoder_a_input, encoder_b_or_direction_input, marker_pulse_input;
  logic [15:0] encCount, markerPos;
  int miscompares = 0, nCompared = 0, cycles = 0;
  // A terminal shows the drive's level where enabled, else the bench's dioExt.
  assign bidirTerminalIn = (bidirTerminalOe & bidirTerminalOut) |
    (~bidirTerminalOe & dioExt);
  drvil_top u_drvil_top (.clk_sys, .resetn, .startInput, .jogInput,
    .coast_stop_input, .alarmActive, .zeroSpeed, .contactor_contact_a,
    .contactor_contact_b, .latch_contact_a, .latch_contact_b, .runActive,
    .outShortSense, .logicOutReq, .logicOutPin, .logicOutEn,
    .shortTripEnable, .shortIndicateEnable, .shortIndicateSel,
    .shortCircuitFlag, .shortTrip, .dioIsOutput, .dioOutReq,
    .bidirTerminalIn, .bidirTerminalOut, .bidirTerminalOe, .dioInLevel,
    .uipSample, .uipThreshold, .uipLogic, .encMode, .encoder_a_input,
    .encoder_b_or_direction_input, .marker_pulse_input, .encCount,
    .markerPos, .markerSeen);
  drvil_plant u_drvil_plant (.clk_sys, .driveRun(runActive), .zeroSpeed,
    .encA(encoder_a_input), .encB(encoder_b_or_direction_input),
    .marker(marker_pulse_input));
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cyc
  task automatic chk(input logic ok, input string msg);
    nCompared++;
    if (ok !== 1'h1) begin
      miscompares++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : chk
  task automatic conclude();
    $display("compared %0d mismatched %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic doReset();
    resetn = 1'h0;
    cyc(5);
    resetn = 1'h1;
    cyc(3);
  endtask : doReset
  task automatic testRun();
    startInput = 1'h1;
    cyc(5);
    chk(contactor_contact_a & contactor_contact_b & latch_contact_a &
      latch_contact_b & runActive, "run");
    startInput = 1'h0;
    cyc(20);
    chk(contactor_contact_a === 1'h1, "dropped before zero speed");
    cyc(40);
    chk(contactor_contact_a === 1'h0 && latch_contact_a === 1'h0, "stop");
    jogInput = 1'h1;
    cyc(5);
    chk(contactor_contact_a === 1'h1, "jog");
    jogInput = 1'h0;
    cyc(60);
  endtask : testRun
  task automatic testCoast();
    startInput = 1'h1;
    cyc(5);
    coast_stop_input = 1'h0;
    cyc(4);
    chk(contactor_contact_a === 1'h0, "coast stop");
    cyc(6);
    chk(contactor_contact_a === 1'h0, "closed with coast low");
    startInput = 1'h0;
    coast_stop_input = 1'h1;
    cyc(60);
  endtask : testCoast
  task automatic testAlarm();
    alarmActive = 1'h1;
    startInput = 1'h1;
    cyc(8);
    chk(contactor_contact_a === 1'h0, "start in alarm");
    startInput = 1'h0;
    alarmActive = 1'h0;
    cyc(4);
    startInput = 1'h1;
    cyc(5);
    chk(contactor_contact_a === 1'h1, "start after clear");
    alarmActive = 1'h1;
    cyc(1);
    alarmActive = 1'h0;
    cyc(2);
    chk(contactor_contact_a === 1'h0, "alarm drop");
    startInput = 1'h0;
    cyc(100);
    startInput = 1'h1;
    cyc(10);
    chk(contactor_contact_a === 1'h0, "early restart");
    startInput = 1'h0;
    doReset();
  endtask : testAlarm
  task automatic testShort();
    startInput = 1'h1;
    cyc(5);
    chk(logicOutPin === 3'h5 && logicOutEn === 3'h7 &&
      bidirTerminalOe === 4'h3 && bidirTerminalOut === 4'h1,
      "outputs");
    outShortSense = 7'h08;
    cyc(2);
    chk(shortCircuitFlag === 1'h1 && logicOutEn === 3'h0 &&
      bidirTerminalOe === 4'h0, "short");
    chk(logicOutPin[2] === 1'h0, "indicate");
    chk(contactor_contact_a === 1'h1 && shortTrip === 1'h0, "trip");
    outShortSense = 7'h00;
    cyc(2);
    chk(shortCircuitFlag === 1'h0 && logicOutPin === 3'h5 &&
      logicOutEn === 3'h7 && bidirTerminalOe === 4'h3 &&
      bidirTerminalOut === 4'h1, "restore");
    shortTripEnable = 1'h1;
    outShortSense = 7'h01;
    cyc(3);
    chk(shortTrip === 1'h1 && contactor_contact_a === 1'h0, "trip");
    outShortSense = 7'h00;
    startInput = 1'h0;
    cyc(5);
    startInput = 1'h1;
    cyc(8);
    chk(contactor_contact_a === 1'h0, "restart after trip");
    startInput = 1'h0;
    shortTripEnable = 1'h0;
    doReset();
  endtask : testShort
  task automatic testInputs();
    dioIsOutput = 4'hc;
    cyc(4);
    chk(dioInLevel === 4'h3 && bidirTerminalOe === 4'hc, "dio");
    dioIsOutput = 4'h3;
    uipSample = {12'h0ff, 12'h800, 12'h7ff, 12'hfff, 12'h000, 12'h801,
      12'h400, 12'hc00};
    cyc(4);
    chk(dioInLevel === 4'hc && uipLogic === 8'h55, "inputs");
  endtask : testInputs
  task automatic encStep(input logic [1:0] mode, input logic sgn,
      input logic quad, input logic [15:0] delta);
    logic [15:0] base;
    encMode = mode;
    cyc(4);
    base = encCount;
    u_drvil_plant.spin(4, sgn, quad);
    chk((encCount - base) === delta, "encoder count");
  endtask : encStep
  task automatic testEncoder();
    encStep(2'h0, 1'h0, 1'h0, 16'h0004);
    encStep(2'h1, 1'h1, 1'h0, 16'hfffc);
    encStep(2'h2, 1'h0, 1'h1, 16'hfff0);
    encStep(2'h3, 1'h0, 1'h1, 16'h0000);
    fork
      u_drvil_plant.mark();
      begin
        for (int i = 0; i < 100 && markerSeen !== 1'h1; i++) cyc(1);
        chk(markerSeen === 1'h1 && markerPos === encCount, "marker");
      end
    join
  endtask : testEncoder
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    doReset();
    testRun();
    testCoast();
    testAlarm();
    testShort();
    testInputs();
    testEncoder();
    conclude();
  end
endmodule : tb_top
